// ---- hw/cbcr_cfg.svh ----
`ifndef CBCR_CFG_SVH
`define CBCR_CFG_SVH

// ************************************************************
// configuration space offsets
// ************************************************************
`define CBCR_OFS_PIN 8'h3D
`define CBCR_OFS_BC 8'h3E
`define CBCR_OFS_SSVID 8'h40
`define CBCR_OFS_SSID 8'h42
`define CBCR_DW_BC 6'h0F
`define CBCR_DW_SS 6'h10

// ************************************************************
// reset values and masks
// ************************************************************
`define CBCR_PIN_LINE_A 8'h01
`define CBCR_BC_RESET 16'h0340
`define CBCR_BC_RW_MASK 16'h07EF
`define CBCR_SS_RESET 16'h0000

// ************************************************************
// field positions
// ************************************************************
`define CBCR_BC_POST 10
`define CBCR_BC_PF1 9
`define CBCR_BC_PF0 8
`define CBCR_BC_ROUTE 7
`define CBCR_BC_CARD_RESET 6
`define CBCR_BC_MABT 5
`define CBCR_BC_VGA 3
`define CBCR_BC_ISA 2
`define CBCR_BC_SERR 1
`define CBCR_BC_PERR 0
`define CBCR_SYS_PAIR_TIE 29
`define CBCR_SYS_ALL_TIE 28
`define CBCR_SYS_SS_LOCK 5

`endif

// ---- hw/cbcr_pkg.sv ----
// ************************************************************
// types of the bridge configuration slice
// ************************************************************
package cbcr_pkg;

  // configuration request, one dword per access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] dw;
    logic [3:0] be;
    logic [31:0] wdata;
  } cbcr_cfg_req_t;

  // address of a host access to be classified
  typedef struct packed {
    logic valid;
    logic is_io;
    logic [31:0] addr;
  } cbcr_acc_t;

  // identification values from the serial loader
  typedef struct packed {
    logic load;
    logic [15:0] vendor;
    logic [15:0] ident;
  } cbcr_ee_t;

endpackage

// ---- hw/cbcr_irq_tie.sv ----
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// interrupt line joining
// ************************************************************
module cbcr_irq_tie #(
  parameter int LINES = 4
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic pair_irq_tie_i,
  input wire logic all_irq_tie_i,
  input wire logic [LINES-1:0] req_i,
  output logic [LINES-1:0] line_o
);

  logic [LINES-1:0] next_line;

  // each line: joined onto line 0 or passed through
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      always_comb begin
        if (g == 0) begin
          if (all_irq_tie_i) begin
            next_line[g] = |req_i;
          end else if (pair_irq_tie_i) begin
            next_line[g] = req_i[0] | req_i[1];
          end else begin
            next_line[g] = req_i[0];
          end
        end else if (all_irq_tie_i || (pair_irq_tie_i && g == 1)) begin
          next_line[g] = 1'b0;
        end else begin
          next_line[g] = req_i[g];
        end
      end
    end
  endgenerate

  // register the lines
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_o <= '0;
    end else begin
      line_o <= next_line;
    end
  end

endmodule

`default_nettype wire

// ---- hw/cbcr_ident.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cbcr_cfg.svh"

// ************************************************************
// subsystem identification pair
// ************************************************************
module cbcr_ident (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  input wire logic subsystem_write_lock_i,
  input wire cbcr_pkg::cbcr_ee_t ee_i,
  output logic [31:0] ident_o
);

  logic [31:0] next_ident;

  // loader wins; host bytes only while unlocked
  always_comb begin
    next_ident = ident_o;
    if (ee_i.load) begin
      next_ident = {ee_i.ident, ee_i.vendor};
    end else if (wr_i && !subsystem_write_lock_i) begin
      for (int b = 0; b < 4; b++) begin
        if (be_i[b]) begin
          next_ident[b*8 +: 8] = wdata_i[b*8 +: 8];
        end
      end
    end
  end

  // only the global reset clears, bus reset never reaches here
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ident_o <= {`CBCR_SS_RESET, `CBCR_SS_RESET};
    end else begin
      ident_o <= next_ident;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_SS_LOCKED: assert property (
    wr_i && subsystem_write_lock_i && !ee_i.load |=> $stable(ident_o))
    else $error("identification changed while locked");
  AST_SS_LOAD: assert property (
    ee_i.load |=> ident_o == {$past(ee_i.ident), $past(ee_i.vendor)})
    else $error("loader values not taken");

endmodule

`default_nettype wire

// ---- hw/cbcr_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cbcr_cfg.svh"

// Function
// - Interrupt pin report of the card function always reads 01h.
// - Tie selections come from system control bits 28 and 29.
// - Pairwise tie joins the second interrupt line onto the first.
// - Smart-card pin is select field plus one, or 01h when all tied.
// - Bridge control bits 15..11 and 4 always read zero.
// - Bit 10 enables burst write posting through the socket.
// - Bits 9 and 8 mark memory windows prefetchable; both reset to 1.
// - Bit 7 routes card interrupts to legacy IRQ instead of PCI lines.
// - Card reset follows bit 6 or a passed-on host bus reset.
// - Host bus reset keeps bit 6; only global reset touches it.
// - Bit 5 set: card master abort gives target abort, and SERR while SERR is enabled.
// - Bit 3 forwards VGA address accesses to the card bus.
// - Bit 2 withholds ISA I/O hitting upper 768 bytes per 1K.
// - Card system error reaches SERR only while bit 1 is set.
// - Bit 0 set: card parity errors reported on card parity signal.
// - Identification writes accepted only while system bit 5 is clear.
// - Identification cleared by global reset only.
// - Serial loader fills both identification values after reset.
// - All-lines tie joins all four interrupt lines onto the first.
module cbcr_regs (
  // clock and global reset
  input wire logic REF_CLK_I,
  input wire logic ARST_N_I,
  // pins from the buses
  input wire logic HOST_BUS_RESET_N_I,
  input wire logic CARD_SYSTEM_ERROR_N_I,
  // configuration access
  input wire cbcr_pkg::cbcr_cfg_req_t CFG_REQ_I,
  output logic [31:0] CFG_RDATA_O,
  output logic CFG_ACK_O,
  // system side
  input wire logic [31:0] SYS_CTRL_I,
  input wire logic [1:0] SC_INT_SEL_I,
  input wire cbcr_pkg::cbcr_ee_t EE_I,
  output logic [7:0] SC_PIN_O,
  // interrupts
  input wire logic [3:0] FUNC_IRQ_I,
  input wire logic CARD_FUNC_IRQ_I,
  output logic [3:0] IRQ_LINE_O,
  output logic LEGACY_IRQ_O,
  // access classification
  input wire cbcr_pkg::cbcr_acc_t ACC_I,
  output logic VGA_FORWARD_O,
  output logic ISA_WITHHOLD_O,
  // errors
  input wire logic CB_MASTER_ABORT_I,
  input wire logic CB_PARITY_DETECT_I,
  input wire logic SERR_ENABLE_I,
  output logic TARGET_ABORT_O,
  output logic SERR_O,
  output logic CARD_PARITY_ERROR_O,
  output logic CARD_PARITY_ERROR_OE_O,
  // bridge controls
  output logic CARD_RESET_O,
  output logic WRITE_POST_ENABLE_O,
  output logic WINDOW0_PREFETCHABLE_O,
  output logic WINDOW1_PREFETCHABLE_O
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic host_bus_reset;
  logic card_system_error;

  // two flops per pin, first stage read only by the second
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
    end else begin
      sync1 <= {CARD_SYSTEM_ERROR_N_I, HOST_BUS_RESET_N_I};
      sync2 <= sync1;
    end
  end

  assign host_bus_reset = ~sync2[0];
  assign card_system_error = ~sync2[1];

  // ************************************************************
  // system control fields
  // ************************************************************
  logic all_irq_tie;
  logic pair_irq_tie;
  logic subsystem_write_lock;

  // tie selections and identification lock from system control
  assign all_irq_tie = SYS_CTRL_I[`CBCR_SYS_ALL_TIE];
  assign pair_irq_tie = SYS_CTRL_I[`CBCR_SYS_PAIR_TIE];
  assign subsystem_write_lock = SYS_CTRL_I[`CBCR_SYS_SS_LOCK];

  // ************************************************************
  // bridge control register
  // ************************************************************
  logic [15:0] bridge_control;
  logic [15:0] next_bridge_control;
  logic [15:0] bc_wdata;
  logic bc_wr;

  assign bc_wr = CFG_REQ_I.wr && CFG_REQ_I.dw == `CBCR_DW_BC;

  // byte merge, then keep only writable bits
  always_comb begin
    bc_wdata = bridge_control;
    if (CFG_REQ_I.be[2]) begin
      bc_wdata[7:0] = CFG_REQ_I.wdata[23:16];
    end
    if (CFG_REQ_I.be[3]) begin
      bc_wdata[15:8] = CFG_REQ_I.wdata[31:24];
    end
    next_bridge_control = bridge_control;
    if (host_bus_reset) begin
      next_bridge_control = `CBCR_BC_RESET;
      next_bridge_control[`CBCR_BC_CARD_RESET] = bridge_control[`CBCR_BC_CARD_RESET];
    end else if (bc_wr) begin
      next_bridge_control = bc_wdata & `CBCR_BC_RW_MASK;
    end
  end

  // global reset loads the documented defaults
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bridge_control <= `CBCR_BC_RESET;
    end else begin
      bridge_control <= next_bridge_control;
    end
  end

  // ************************************************************
  // identification and interrupt lines
  // ************************************************************
  logic [31:0] ident;
  logic [3:0] irq_req;

  cbcr_ident u_ident (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .wr_i(CFG_REQ_I.wr && CFG_REQ_I.dw == `CBCR_DW_SS),
    .be_i(CFG_REQ_I.be),
    .wdata_i(CFG_REQ_I.wdata),
    .subsystem_write_lock_i(subsystem_write_lock),
    .ee_i(EE_I),
    .ident_o(ident)
  );

  // card interrupt joins line A unless routed to legacy IRQ
  always_comb begin
    irq_req = FUNC_IRQ_I;
    irq_req[0] = FUNC_IRQ_I[0] | (CARD_FUNC_IRQ_I & ~bridge_control[`CBCR_BC_ROUTE]);
  end

  cbcr_irq_tie #(
    .LINES(4)
  ) u_irq_tie (
    .clk_i(REF_CLK_I),
    .arst_n_i(ARST_N_I),
    .pair_irq_tie_i(pair_irq_tie),
    .all_irq_tie_i(all_irq_tie),
    .req_i(irq_req),
    .line_o(IRQ_LINE_O)
  );

  // ************************************************************
  // registered outputs, then parity pin and control levels driven directly
  // ************************************************************
  logic [31:0] next_rdata;
  logic [7:0] next_sc_pin;
  logic next_vga;
  logic next_isa;
  logic next_tabort;
  logic next_serr;
  logic next_perr;
  logic vga_hit;
  logic isa_hit;
  logic low_page;

  // read mux, pin report fixed at line A
  always_comb begin
    case (CFG_REQ_I.dw)
      `CBCR_DW_BC: next_rdata = {bridge_control, `CBCR_PIN_LINE_A, 8'h00};
      `CBCR_DW_SS: next_rdata = ident;
      default: next_rdata = 32'h0000_0000;
    endcase
    if (!CFG_REQ_I.rd) begin
      next_rdata = CFG_RDATA_O;
    end
  end

  // smart-card pin report
  always_comb begin
    if (all_irq_tie) begin
      next_sc_pin = `CBCR_PIN_LINE_A;
    end else begin
      next_sc_pin = 8'(SC_INT_SEL_I) + `CBCR_PIN_LINE_A;
    end
  end

  // VGA and ISA alias decode
  always_comb begin
    low_page = ACC_I.addr[31:16] == 16'h0000;
    if (ACC_I.is_io) begin
      vga_hit = low_page && ((ACC_I.addr[15:4] == 12'h03B && ACC_I.addr[3:2] != 2'h3)
                || ACC_I.addr[15:5] == 11'h01E);
    end else begin
      vga_hit = ACC_I.addr[31:17] == 15'h0005;
    end
    isa_hit = ACC_I.is_io && low_page && ACC_I.addr[9:8] != 2'h0;
    next_vga = ACC_I.valid && vga_hit && bridge_control[`CBCR_BC_VGA];
    next_isa = ACC_I.valid && isa_hit && bridge_control[`CBCR_BC_ISA];
  end

  // error reporting
  always_comb begin
    next_tabort = CB_MASTER_ABORT_I && bridge_control[`CBCR_BC_MABT];
    next_serr = SERR_ENABLE_I && (next_tabort
                || (card_system_error && bridge_control[`CBCR_BC_SERR]));
    next_perr = CB_PARITY_DETECT_I && bridge_control[`CBCR_BC_PERR];
  end

  // output flops
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      CFG_RDATA_O <= 32'h0000_0000;
      CFG_ACK_O <= 1'b0;
      SC_PIN_O <= `CBCR_PIN_LINE_A;
      VGA_FORWARD_O <= 1'b0;
      ISA_WITHHOLD_O <= 1'b0;
      TARGET_ABORT_O <= 1'b0;
      SERR_O <= 1'b0;
      CARD_PARITY_ERROR_OE_O <= 1'b0;
      CARD_RESET_O <= 1'b1;
    end else begin
      CFG_RDATA_O <= next_rdata;
      CFG_ACK_O <= CFG_REQ_I.rd | CFG_REQ_I.wr;
      SC_PIN_O <= next_sc_pin;
      VGA_FORWARD_O <= next_vga;
      ISA_WITHHOLD_O <= next_isa;
      TARGET_ABORT_O <= next_tabort;
      SERR_O <= next_serr;
      CARD_PARITY_ERROR_OE_O <= next_perr;
      CARD_RESET_O <= next_bridge_control[`CBCR_BC_CARD_RESET] | host_bus_reset;
    end
  end

  // open-drain parity pin pulls low only
  assign CARD_PARITY_ERROR_O = 1'b0;

  // control levels straight from the register; legacy IRQ is the card interrupt gated by bit 7
  assign WRITE_POST_ENABLE_O = bridge_control[`CBCR_BC_POST];
  assign WINDOW1_PREFETCHABLE_O = bridge_control[`CBCR_BC_PF1];
  assign WINDOW0_PREFETCHABLE_O = bridge_control[`CBCR_BC_PF0];
  assign LEGACY_IRQ_O = CARD_FUNC_IRQ_I & bridge_control[`CBCR_BC_ROUTE];

  // ************************************************************
  // checks
  // ************************************************************
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);

  AST_PIN_FIXED: assert property (
    CFG_REQ_I.rd && CFG_REQ_I.dw == `CBCR_DW_BC |=> CFG_RDATA_O[15:8] == 8'h01)
    else $error("interrupt pin report not 01h");
  AST_RSVD_ZERO: assert property (
    CFG_REQ_I.rd && CFG_REQ_I.dw == `CBCR_DW_BC
    |=> CFG_RDATA_O[31:27] == 5'h00 && !CFG_RDATA_O[20])
    else $error("reserved bridge control bits read nonzero");
  AST_PAIR_TIE: assert property (
    pair_irq_tie && !all_irq_tie && $stable(irq_req)
    |=> !IRQ_LINE_O[1] && IRQ_LINE_O[0] == ($past(irq_req[0]) | $past(irq_req[1])))
    else $error("pairwise tie not applied");
  AST_ALL_TIE: assert property (
    all_irq_tie |=> IRQ_LINE_O[3:1] == 3'h0 && IRQ_LINE_O[0] == |$past(irq_req))
    else $error("all-lines tie not applied");
  AST_SC_PIN: assert property (
    all_irq_tie |=> SC_PIN_O == 8'h01)
    else $error("smart-card pin not 01h under tie");
  AST_CARD_RESET_KEEP: assert property (
    host_bus_reset |=> bridge_control[`CBCR_BC_CARD_RESET] == $past(bridge_control[`CBCR_BC_CARD_RESET]))
    else $error("card reset bit changed by bus reset");
  AST_CARD_RESET_OUT: assert property (
    bridge_control[`CBCR_BC_CARD_RESET] || $past(host_bus_reset) |-> CARD_RESET_O)
    else $error("card reset not asserted");
  AST_MABT: assert property (
    CB_MASTER_ABORT_I |=> TARGET_ABORT_O == $past(bridge_control[`CBCR_BC_MABT]))
    else $error("master abort report wrong");
  AST_SERR_GATE: assert property (
    card_system_error && !bridge_control[`CBCR_BC_SERR] && !CB_MASTER_ABORT_I |=> !SERR_O)
    else $error("card system error forwarded while disabled");
  AST_ISA: assert property (
    ACC_I.valid && isa_hit && bridge_control[`CBCR_BC_ISA] |=> ISA_WITHHOLD_O)
    else $error("isa alias not withheld");
  AST_PERR: assert property (
    CB_PARITY_DETECT_I |=> CARD_PARITY_ERROR_OE_O == $past(bridge_control[`CBCR_BC_PERR]))
    else $error("parity report wrong");

  COV_ALL_TIE: cover property (all_irq_tie && |FUNC_IRQ_I[3:1]);
  COV_MABT: cover property (CB_MASTER_ABORT_I && bridge_control[`CBCR_BC_MABT]);
  COV_BUS_RESET: cover property (host_bus_reset && bridge_control[`CBCR_BC_CARD_RESET]);

endmodule

`default_nettype wire

// ---- tb/cbcr_card_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// card side: turns bench event requests into card pins
// ************************************************************
module cbcr_card_model (
  // event requests {irq, syserr, parity, abort}
  input wire logic [3:0] ev_i,
  // card pins
  output logic card_system_error_n_o,
  output logic parity_detect_o,
  output logic master_abort_o,
  output logic func_irq_o
);
  // system error pin is active low, the rest active high
  assign card_system_error_n_o = ~ev_i[2];
  assign parity_detect_o = ev_i[1];
  assign master_abort_o = ev_i[0];
  assign func_irq_o = ev_i[3];
endmodule

`default_nettype wire

// ---- tb/test_cbcr_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "cbcr_cfg.svh"

module test_cbcr_regs;
  // ************************************************************
  // stimulus and design connections
  // ************************************************************
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic bus_rst_n = 1'b1;
  logic serr_en = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [3:0] func_irq = 4'h0;
  logic [1:0] sc_sel = 2'h0;
  logic [31:0] sys = 32'h0000_0020;
  cbcr_pkg::cbcr_cfg_req_t req = '0;
  cbcr_pkg::cbcr_ee_t ee = '0;
  cbcr_pkg::cbcr_acc_t acc = '0;
  logic syserr_n, par, mabt, cirq, ack, legacy, vga, isa, tabt, serr;
  logic perr, perr_oe, card_reset, post, pf0, pf1;
  logic [31:0] rdata;
  logic [7:0] sc_pin;
  logic [3:0] irq_line;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  cbcr_card_model u_cbcr_card_model (.ev_i(ev), .card_system_error_n_o(syserr_n),
    .parity_detect_o(par), .master_abort_o(mabt), .func_irq_o(cirq));

  cbcr_regs u_cbcr_regs (.REF_CLK_I(clk), .ARST_N_I(arst_n), .HOST_BUS_RESET_N_I(bus_rst_n),
    .CARD_SYSTEM_ERROR_N_I(syserr_n), .CFG_REQ_I(req), .CFG_RDATA_O(rdata), .CFG_ACK_O(ack),
    .SYS_CTRL_I(sys), .SC_INT_SEL_I(sc_sel), .EE_I(ee), .SC_PIN_O(sc_pin),
    .FUNC_IRQ_I(func_irq), .CARD_FUNC_IRQ_I(cirq), .IRQ_LINE_O(irq_line),
    .LEGACY_IRQ_O(legacy), .ACC_I(acc), .VGA_FORWARD_O(vga), .ISA_WITHHOLD_O(isa),
    .CB_MASTER_ABORT_I(mabt), .CB_PARITY_DETECT_I(par), .SERR_ENABLE_I(serr_en),
    .TARGET_ABORT_O(tabt), .SERR_O(serr), .CARD_PARITY_ERROR_O(perr),
    .CARD_PARITY_ERROR_OE_O(perr_oe), .CARD_RESET_O(card_reset), .WRITE_POST_ENABLE_O(post),
    .WINDOW0_PREFETCHABLE_O(pf0), .WINDOW1_PREFETCHABLE_O(pf1));

  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one config access; request lowered and one idle cycle after the answer
  task automatic cfg(input logic wr, input logic [5:0] dw, input logic [3:0] be,
    input logic [31:0] wd, output logic [31:0] rd);
    req = '{wr: wr, rd: ~wr, dw: dw, be: be, wdata: wd};
    @(negedge clk);
    req = '0;
    chk(32'(ack), 32'h0000_0001);
    rd = rdata;
    @(negedge clk);
  endtask

  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // expected lines after joining; tie[0] all lines, tie[1] pairwise
  function automatic logic [3:0] irq_exp(input logic [3:0] f, input logic c,
    input logic [1:0] tie);
    logic [3:0] a;
    a = f | {3'b000, c};
    if (tie[0]) return {3'b000, |a};
    if (tie[1]) return {a[3:2], 1'b0, a[0] | a[1]};
    return a;
  endfunction

  function automatic logic vga_exp(input logic io, input logic [31:0] a);
    if (io) return (a >= 32'h0000_03B0 && a <= 32'h0000_03BB) ||
      (a >= 32'h0000_03C0 && a <= 32'h0000_03DF);
    return a >= 32'h000A_0000 && a <= 32'h000B_FFFF;
  endfunction

  function automatic logic isa_exp(input logic io, input logic [31:0] a);
    return io && a[31:16] == 16'h0000 && a[9:8] != 2'b00;
  endfunction

  localparam logic [32:0] ACC_TAB [14] = '{33'h0_000A_0000, 33'h0_000B_FFFF,
    33'h0_0009_FFFF, 33'h0_000C_0000, 33'h1_0000_03B0, 33'h1_0000_03BB, 33'h1_0000_03BC,
    33'h1_0000_03C0, 33'h1_0000_03DF, 33'h1_0000_03E0, 33'h1_0000_0100, 33'h1_0000_00FF,
    33'h1_0001_0100, 33'h1_0000_FFFF};

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] v;
    logic [31:0] r;
    logic [32:0] t;
    void'($urandom(36));
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    // reset values
    cfg(1'b0, `CBCR_DW_BC, 4'hF, 32'h0000_0000, r);
    chk(r, {`CBCR_BC_RESET, `CBCR_PIN_LINE_A, 8'h00});
    chk(32'({card_reset, pf1, pf0, post}), 32'h0000_000E);
    // an unmapped dword reads back zero
    cfg(1'b0, 6'h11, 4'hF, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    // bridge control writes, interrupts and error paths
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 32'h0000_FFFF : $urandom;
      sys[29:28] = 2'($urandom);
      cfg(1'b1, `CBCR_DW_BC, 4'hF, {v[15:0], 16'hFFFF}, r);
      cfg(1'b0, `CBCR_DW_BC, 4'hF, 32'h0000_0000, r);
      chk(r, {v[15:0] & `CBCR_BC_RW_MASK, 16'h0100});
      chk(32'({post, pf1, pf0, card_reset}), 32'({v[10], v[9], v[8], v[6]}));
      func_irq = 4'($urandom);
      sc_sel = 2'($urandom);
      serr_en = 1'($urandom);
      ev = {1'($urandom), 3'b011};
      @(negedge clk);
      t = {ev[3], 32'h0};
      ev[1:0] = 2'b00;
      chk(32'(irq_line), 32'(irq_exp(func_irq, t[32] & ~v[7], sys[29:28])));
      chk(32'(legacy), 32'(t[32] & v[7]));
      chk(32'(sc_pin), sys[28] ? 32'h0000_0001 : 32'(sc_sel) + 32'h0000_0001);
      chk(32'({tabt, serr}), 32'({v[5], v[5] & serr_en}));
      chk(32'({perr_oe, perr}), 32'({v[0], 1'b0}));
      ev = 4'b0100;
      repeat (5) @(negedge clk);
      chk(32'(serr), 32'(v[1] & serr_en));
      ev = 4'b0000;
      repeat (5) @(negedge clk);
    end
    // access classification, filters off then on
    for (int p = 0; p < 2; p++) begin
      cfg(1'b1, `CBCR_DW_BC, 4'hC, {16'(p * 12), 16'h0000}, r);
      for (int i = 0; i < 22; i++) begin
        t = (i < 14) ? ACC_TAB[i] : {1'($urandom), 12'h000, 20'($urandom)};
        acc = '{valid: 1'b1, is_io: t[32], addr: t[31:0]};
        @(negedge clk);
        chk(32'(vga), 32'(p & vga_exp(t[32], t[31:0])));
        chk(32'(isa), 32'(p & isa_exp(t[32], t[31:0])));
      end
      acc = '0;
    end
    // identification lock, partial enables and serial load
    v = $urandom;
    cfg(1'b1, `CBCR_DW_SS, 4'hF, v, r);
    cfg(1'b0, `CBCR_DW_SS, 4'hF, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    sys[5] = 1'b0;
    cfg(1'b1, `CBCR_DW_SS, 4'hF, v, r);
    cfg(1'b1, `CBCR_DW_SS, 4'h3, ~v, r);
    cfg(1'b0, `CBCR_DW_SS, 4'hF, 32'h0000_0000, r);
    chk(r, {v[31:16], ~v[15:0]});
    // host bus reset keeps the card reset bit and the identification
    cfg(1'b1, `CBCR_DW_BC, 4'hC, 32'h0000_0000, r);
    chk(32'(card_reset), 32'h0000_0000);
    bus_rst_n = 1'b0;
    repeat (5) @(negedge clk);
    chk(32'(card_reset), 32'h0000_0001);
    bus_rst_n = 1'b1;
    repeat (5) @(negedge clk);
    cfg(1'b0, `CBCR_DW_BC, 4'hF, 32'h0000_0000, r);
    chk(r, 32'h0300_0100);
    cfg(1'b0, `CBCR_DW_SS, 4'hF, 32'h0000_0000, r);
    chk(r, {v[31:16], ~v[15:0]});
    sys[5] = 1'b1;
    ee = '{load: 1'b1, vendor: v[31:16], ident: v[15:0]};
    @(negedge clk);
    ee = '0;
    cfg(1'b0, `CBCR_DW_SS, 4'hF, 32'h0000_0000, r);
    chk(r, {v[15:0], v[31:16]});
    // global reset clears identification and restores card reset
    arst_n = 1'b0;
    @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    cfg(1'b0, `CBCR_DW_SS, 4'hF, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    cfg(1'b0, `CBCR_DW_BC, 4'hF, 32'h0000_0000, r);
    chk(r, 32'h0340_0100);
    complete_run();
  end
endmodule

`default_nettype wire
